// ### include/xbw_consts.svh
// Constants of the external write sequencer: register offsets, field positions,
// reset levels and timing counts. Included by the package and the design files.
`ifndef XBW_CONSTS_SVH
`define XBW_CONSTS_SVH

// APB register byte offsets
`define XBW_OFF_CTRL 12'h000
`define XBW_OFF_TIMING 12'h004
`define XBW_OFF_ADDR 12'h008
`define XBW_OFF_DATA 12'h00C
`define XBW_OFF_STATUS 12'h010

// Control and status bit positions
`define XBW_CTRL_START 0
`define XBW_STAT_BUSY 0
`define XBW_STAT_DONE 1
`define XBW_STAT_STRETCH 2

// Timing register field positions
`define XBW_TIM_LEAD_LO 0
`define XBW_TIM_LEAD_HI 1
`define XBW_TIM_ACT_LO 2
`define XBW_TIM_ACT_HI 4
`define XBW_TIM_TRAIL_LO 5
`define XBW_TIM_TRAIL_HI 6
`define XBW_TIM_WEN 7
`define XBW_TIM_WKIND 8
`define XBW_TIM_DBL 9
`define XBW_TIM_BUS32 10

// Widths
`define XBW_ADDR_W 20
`define XBW_DATA_W 32
`define XBW_DIV_W 1

// Timing clock divider: one timing cycle is two system cycles
`define XBW_DIV_LAST 1'h1
`define XBW_DIV_ZERO 1'h0

// Count constants
`define XBW_CNT_ZERO 4'h0
`define XBW_CNT_ONE 4'h1
`define XBW_ASYNC_EARLY 4'h2

// Reset and idle levels
`define XBW_PIN_IDLE 1'b1
`define XBW_WORD_ZERO 32'h0000_0000

`endif

// ### include/xbw_pkg.sv
// Types shared by the external write sequencer and its wait gate.
// Assumes xbw_consts.svh is reachable on the include path.
`include "xbw_consts.svh"

package xbw_pkg;

    typedef logic [`XBW_DIV_W-1:0] xbw_div_t;
    typedef logic [3:0] xbw_cnt_t;

    typedef enum logic [2:0] {
        XBW_IDLE = 3'b000,
        XBW_ALIGN = 3'b001,
        XBW_LEAD = 3'b010,
        XBW_ACT = 3'b011,
        XBW_TRAIL = 3'b100
    } xbw_state_e;

    typedef struct packed {
        logic seen;
    } xbw_gate_s;

    typedef struct packed {
        xbw_state_e state;
        xbw_cnt_t cnt;
        xbw_div_t div;
        logic bph;
        logic go;
        logic done;
        logic stretched;
        logic [1:0] lead;
        logic [2:0] act;
        logic [1:0] trail;
        logic wen;
        logic wkind;
        logic dbl;
        logic bus32;
        logic [`XBW_ADDR_W-1:0] addr;
        logic [`XBW_DATA_W-1:0] wdata;
        logic sync1;
        logic sync2;
        logic bclk;
        logic zone_n;
        logic dir;
        logic we0_n;
        logic we1_n;
        logic [`XBW_ADDR_W-1:0] a_out;
        logic [`XBW_DATA_W-1:0] d_out;
        logic d_oe;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } xbw_core_s;

endpackage : xbw_pkg

// ### hw/xbw_wait_gate.sv
// Ready sampling gate for the active period of an external write.
// Assumes ready_i is already synchronised and tick_i marks timing-clock cycles.
`timescale 1ns/1ps
`include "xbw_consts.svh"

module xbw_wait_gate
    import xbw_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic tick_i,
    input wire logic active_i,
    input wire logic [3:0] elapsed_i,
    input wire logic [3:0] active_len_i,
    input wire logic sample_en_i,
    input wire logic sample_kind_i,
    input wire logic ready_i,
    output logic advance_o,
    output logic need_o,
    output logic [3:0] sample_pt_o
);

    xbw_gate_s q;
    xbw_gate_s d;

    // Sample point in elapsed active cycles; async looks two cycles early
    always_comb
    begin
        d = q;
        sample_pt_o = active_len_i;
        if (sample_kind_i)
        begin
            sample_pt_o = (active_len_i > `XBW_ASYNC_EARLY) ?
                          xbw_cnt_t'(active_len_i - `XBW_ASYNC_EARLY) : `XBW_CNT_ONE;
        end
        // A low sample holds the count, so the next cycle resamples
        need_o = sample_en_i & active_i & ~q.seen & (elapsed_i >= sample_pt_o);
        advance_o = ~need_o | ready_i;
        // Once ready is seen high the rest of the active period runs freely
        d.seen = active_i & (q.seen | (tick_i & need_o & ready_i));
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
            q <= '0;
        else
            q <= d;
    end

endmodule : xbw_wait_gate

// ### hw/xbw_write_seq.sv
// External parallel interface write sequencer with ready-stretched active phase.
// Assumes an APB master on clk_sys_i and an external device driving the ready pin.
//
// Added by the designer: the APB slave port and the register addresses.
`timescale 1ns/1ps
`include "xbw_consts.svh"

module xbw_write_seq
    import xbw_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic external_wait_release_i,
    output logic pready_o,
    output logic pslverr_o,
    output logic [31:0] prdata_o,
    output logic bus_clock_output_o,
    output logic zone_select_n_o,
    output logic direction_line_o,
    output logic write_strobe_low_lane_n_o,
    output logic write_strobe_high_lane_n_o,
    output logic [`XBW_ADDR_W-1:0] ext_addr_o,
    output logic [`XBW_DATA_W-1:0] ext_data_o,
    output logic ext_data_oe_o
);

    xbw_core_s q;
    xbw_core_s d;
    logic tick;
    logic busy;
    logic apb_wr;
    logic apb_setup;
    logic wr_next;
    logic adv;
    logic need;
    logic [3:0] e_new;
    logic [3:0] sample_pt;
    logic [3:0] lead_len;
    logic [3:0] act_len;
    logic [3:0] trail_len;

    // A zero setting would give a period of no length; treat it as one cycle
    function automatic xbw_cnt_t period_len(input logic [2:0] v);
        xbw_cnt_t r;
        r = {1'b0, v};
        if (r == `XBW_CNT_ZERO)
            r = `XBW_CNT_ONE;
        return r;
    endfunction : period_len

    function automatic logic reg_hit(input logic [11:0] a);
        return (a == `XBW_OFF_CTRL) || (a == `XBW_OFF_TIMING) || (a == `XBW_OFF_ADDR) ||
               (a == `XBW_OFF_DATA) || (a == `XBW_OFF_STATUS);
    endfunction : reg_hit

    // Timing-clock enable and derived lengths
    assign tick = (q.div == `XBW_DIV_LAST);
    assign busy = q.go | (q.state != XBW_IDLE);
    assign e_new = xbw_cnt_t'(q.cnt + `XBW_CNT_ONE);
    assign lead_len = period_len({1'b0, q.lead});
    assign act_len = period_len(q.act);
    assign trail_len = period_len({1'b0, q.trail});
    assign apb_setup = psel_i & penable_i & ~q.pready;
    assign apb_wr = psel_i & penable_i & pwrite_i & q.pready;

    xbw_wait_gate xbw_wait_gate_inst (
        .clk_sys_i(clk_sys_i),
        .srst_i(srst_i),
        .tick_i(tick),
        .active_i(q.state == XBW_ACT),
        .elapsed_i(e_new),
        .active_len_i(act_len),
        .sample_en_i(q.wen),
        .sample_kind_i(q.wkind),
        .ready_i(q.sync2),
        .advance_o(adv),
        .need_o(need),
        .sample_pt_o(sample_pt)
    );

    always_comb
    begin
        d = q;
        wr_next = 1'b0;
        // Divider and bus clock phase; phase stays 0 unless the period is doubled
        d.div = tick ? `XBW_DIV_ZERO : xbw_div_t'(q.div + 1'b1);
        d.bph = tick ? (q.dbl & ~q.bph) : q.bph;
        // Ready pin crosses into our clock through two flops
        d.sync1 = external_wait_release_i;
        d.sync2 = q.sync1;
        // APB slave: one wait state, read data captured on the same edge that raises pready
        d.pready = apb_setup;
        d.pslverr = apb_setup & ~reg_hit(paddr_i);
        if (apb_setup)
        begin
            d.prdata = `XBW_WORD_ZERO;
            unique case (paddr_i)
                `XBW_OFF_TIMING:
                begin
                    d.prdata[`XBW_TIM_LEAD_HI:`XBW_TIM_LEAD_LO] = q.lead;
                    d.prdata[`XBW_TIM_ACT_HI:`XBW_TIM_ACT_LO] = q.act;
                    d.prdata[`XBW_TIM_TRAIL_HI:`XBW_TIM_TRAIL_LO] = q.trail;
                    d.prdata[`XBW_TIM_WEN] = q.wen;
                    d.prdata[`XBW_TIM_WKIND] = q.wkind;
                    d.prdata[`XBW_TIM_DBL] = q.dbl;
                    d.prdata[`XBW_TIM_BUS32] = q.bus32;
                end
                `XBW_OFF_ADDR: d.prdata[`XBW_ADDR_W-1:0] = q.addr;
                `XBW_OFF_DATA: d.prdata = q.wdata;
                `XBW_OFF_STATUS:
                begin
                    d.prdata[`XBW_STAT_BUSY] = busy;
                    d.prdata[`XBW_STAT_DONE] = q.done;
                    d.prdata[`XBW_STAT_STRETCH] = q.stretched;
                end
                default: d.prdata = `XBW_WORD_ZERO;
            endcase
        end
        // Settings are frozen while busy so an access never sees them change
        if (apb_wr)
        begin
            unique case (paddr_i)
                `XBW_OFF_CTRL:
                    if (pwdata_i[`XBW_CTRL_START] && !busy)
                    begin
                        d.go = 1'b1;
                        d.stretched = 1'b0;
                    end
                `XBW_OFF_TIMING:
                    if (!busy)
                    begin
                        d.lead = pwdata_i[`XBW_TIM_LEAD_HI:`XBW_TIM_LEAD_LO];
                        d.act = pwdata_i[`XBW_TIM_ACT_HI:`XBW_TIM_ACT_LO];
                        d.trail = pwdata_i[`XBW_TIM_TRAIL_HI:`XBW_TIM_TRAIL_LO];
                        d.wen = pwdata_i[`XBW_TIM_WEN];
                        d.wkind = pwdata_i[`XBW_TIM_WKIND];
                        d.dbl = pwdata_i[`XBW_TIM_DBL];
                        d.bus32 = pwdata_i[`XBW_TIM_BUS32];
                    end
                `XBW_OFF_ADDR:
                    if (!busy)
                        d.addr = pwdata_i[`XBW_ADDR_W-1:0];
                `XBW_OFF_DATA:
                    if (!busy)
                        d.wdata = pwdata_i;
                `XBW_OFF_STATUS:
                    if (pwdata_i[`XBW_STAT_DONE])
                        d.done = 1'b0;
                default: d.go = q.go;
            endcase
        end
        // Sequencer advances once per timing cycle
        if (tick)
        begin
            unique case (q.state)
                XBW_IDLE:
                    if (q.go)
                    begin
                        d.go = 1'b0;
                        d.cnt = `XBW_CNT_ZERO;
                        // Next cycle in the low half of the bus clock: align first
                        d.state = d.bph ? XBW_ALIGN : XBW_LEAD;
                    end
                XBW_ALIGN:
                    d.state = XBW_LEAD;
                XBW_LEAD:
                    if (e_new >= lead_len)
                    begin
                        d.state = XBW_ACT;
                        d.cnt = `XBW_CNT_ZERO;
                    end
                    else
                        d.cnt = e_new;
                XBW_ACT:
                    if (adv)
                    begin
                        if (e_new >= act_len)
                        begin
                            d.state = XBW_TRAIL;
                            d.cnt = `XBW_CNT_ZERO;
                        end
                        else
                            d.cnt = e_new;
                    end
                    else
                        d.stretched = 1'b1;
                XBW_TRAIL:
                    if (e_new >= trail_len)
                    begin
                        d.state = XBW_IDLE;
                        d.done = 1'b1; // Set placed after the clear so it wins
                    end
                    else
                        d.cnt = e_new;
                default: d.state = XBW_IDLE;
            endcase
        end
        // Pins follow the next state so they change with the bus clock edge
        wr_next = (d.state == XBW_LEAD) || (d.state == XBW_ACT) || (d.state == XBW_TRAIL);
        d.zone_n = ~wr_next;
        d.dir = ~wr_next;
        d.we0_n = ~(d.state == XBW_ACT);
        d.a_out = wr_next ? q.addr : {q.a_out[`XBW_ADDR_W-1:1], `XBW_PIN_IDLE};
        d.we1_n = q.bus32 ? d.we0_n : d.a_out[0];
        d.d_out = wr_next ? q.wdata : q.d_out;
        // Drive from strobe low; let go one cycle after direction returns high
        d.d_oe = (d.state == XBW_ACT) || (d.state == XBW_TRAIL) || (q.d_oe && !q.dir);
        d.bclk = q.dbl ? ~d.bph : (d.div == `XBW_DIV_ZERO);
    end

    // Single register stage for all state; pins idle inactive from reset
    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
        begin
            q <= '0;
            q.zone_n <= `XBW_PIN_IDLE;
            q.dir <= `XBW_PIN_IDLE;
            q.we0_n <= `XBW_PIN_IDLE;
            q.we1_n <= `XBW_PIN_IDLE;
            q.a_out[0] <= `XBW_PIN_IDLE;
        end
        else
            q <= d;
    end

    assign pready_o = q.pready;
    assign pslverr_o = q.pslverr;
    assign prdata_o = q.prdata;
    assign bus_clock_output_o = q.bclk;
    assign zone_select_n_o = q.zone_n;
    assign direction_line_o = q.dir;
    assign write_strobe_low_lane_n_o = q.we0_n;
    assign write_strobe_high_lane_n_o = q.we1_n;
    assign ext_addr_o = q.a_out;
    assign ext_data_o = q.d_out;
    assign ext_data_oe_o = q.d_oe;

    // Checks on the sequencer and its pins
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (srst_i);

    lead_on_rise_a: assert property ($rose(q.state == XBW_LEAD) |-> $rose(bus_clock_output_o))
        else $error("lead period not started on bus clock rise");
    align_insert_a: assert property (q.state == XBW_IDLE && q.go && tick && q.dbl && !q.bph
        |=> q.state == XBW_ALIGN ##2 q.state == XBW_LEAD)
        else $error("alignment cycle missing");
    align_quiet_a: assert property (q.state == XBW_ALIGN |-> zone_select_n_o && direction_line_o
        && write_strobe_low_lane_n_o && !ext_data_oe_o)
        else $error("controls active in alignment cycle");
    idle_addr_a: assert property (q.state inside {XBW_IDLE, XBW_ALIGN} && $past(q.state) != XBW_TRAIL
        |-> ext_addr_o[0] && $stable(ext_addr_o))
        else $error("idle address not held");
    high_lane_a: assert property (!q.bus32 && !$past(q.bus32)
        |-> write_strobe_high_lane_n_o == ext_addr_o[0])
        else $error("high lane pin not address bit in 16-bit mode");
    write_lines_a: assert property (!write_strobe_low_lane_n_o |-> !zone_select_n_o
        && !direction_line_o)
        else $error("strobe low without zone and direction");
    data_drive_a: assert property ($rose(ext_data_oe_o) |-> !write_strobe_low_lane_n_o)
        else $error("data driven before strobe");
    data_release_a: assert property ($rose(direction_line_o) |-> ext_data_oe_o ##1 !ext_data_oe_o)
        else $error("data bus release timing wrong");
    trail_hold_a: assert property (q.state == XBW_TRAIL |-> ext_data_oe_o && $stable(ext_data_o)
        && write_strobe_low_lane_n_o)
        else $error("write data not held in trail");
    sync_done_a: assert property (q.state == XBW_ACT && tick && q.wen && !q.wkind
        && e_new == act_len && q.sync2 |=> q.state == XBW_TRAIL)
        else $error("sync ready high did not complete");
    wait_hold_a: assert property (q.state == XBW_ACT && tick && need && !q.sync2
        |=> q.state == XBW_ACT && $stable(q.cnt))
        else $error("ready low did not stretch access");
    async_point_a: assert property (q.wkind && act_len > `XBW_ASYNC_EARLY
        |-> sample_pt == act_len - `XBW_ASYNC_EARLY)
        else $error("async sample point wrong");
    no_wait_a: assert property (q.state == XBW_ACT && tick && !q.wen && e_new == act_len
        |=> q.state == XBW_TRAIL)
        else $error("access stalled with sampling off");
    lead_len_a: assert property (q.state == XBW_LEAD && tick && e_new >= lead_len
        |=> q.state == XBW_ACT)
        else $error("lead period length wrong");

    stretch_c: cover property (q.state == XBW_ACT && tick && need && !q.sync2);
    async_c: cover property (q.wkind && q.wen && $rose(q.state == XBW_TRAIL));
    align_c: cover property (q.state == XBW_ALIGN);
    narrow_c: cover property (!q.bus32 && !write_strobe_low_lane_n_o);

endmodule : xbw_write_seq

// ### testbench/xbw_mem_model.sv
// Partner model: external peripheral that answers writes with a wait-release pin.
// Assumes registered sequencer pins on clk_sys_i; the release pin has a pull-up.
`timescale 1ns/1ps
module xbw_mem_model (
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic bclk_i,
    input wire logic zone_n_i,
    input wire logic dir_i,
    input wire logic we0_n_i,
    input wire logic we1_n_i,
    input wire logic [19:0] addr_i,
    input wire logic [31:0] data_i,
    input wire logic oe_i,
    input wire logic bus32_i,
    input wire logic [7:0] hold_i,
    output logic ready_o,
    output logic [19:0] cap_addr_o,
    output logic [31:0] cap_data_o,
    output int strobe_len_o,
    output int zone_len_o,
    output int bad_o
);
    logic [7:0] cnt_q = 8'h00;
    logic rel_q = 1'b0;
    logic zone_p = 1'b1;
    logic bclk_p = 1'b0;
    logic seen_q = 1'b0;
    logic [19:0] last_q = 20'h0_0000;

    // Pulled up when deselected; held low until hold_i cycles after strobe fall
    assign ready_o = zone_n_i | rel_q | (hold_i == 8'h00);

    initial
    begin
        bad_o = 0;
        strobe_len_o = 0;
        zone_len_o = 0;
    end

    // Bus watch and capture; checks stay off in reset, where pins may still be unknown
    always @(posedge clk_sys_i)
    begin
        zone_p <= zone_n_i;
        bclk_p <= bclk_i;
        cnt_q <= we0_n_i ? 8'h00 : cnt_q + 8'h01;
        rel_q <= !zone_n_i && (rel_q || (!we0_n_i && cnt_q + 8'h01 >= hold_i));
        seen_q <= (seen_q && !(zone_n_i && zone_p)) || !we0_n_i;
        last_q <= srst_i ? 20'h0_0000 : (!zone_n_i ? addr_i : last_q);
        if (!we0_n_i)
        begin
            cap_data_o <= data_i;
            cap_addr_o <= addr_i;
            strobe_len_o <= int'(cnt_q) + 1;
        end
        if (!zone_n_i)
            zone_len_o <= zone_p ? 1 : zone_len_o + 1;
        if (!srst_i)
        begin
            if (zone_p && !zone_n_i && !(bclk_i && !bclk_p)) bad_o++;
            if (zone_n_i && zone_p && !(we0_n_i && dir_i && !oe_i && addr_i[0] &&
                addr_i[19:1] == last_q[19:1])) bad_o++;
            if (!zone_n_i && dir_i) bad_o++;
            if (oe_i && !seen_q && we0_n_i) bad_o++;
            if (we1_n_i !== (bus32_i ? we0_n_i : addr_i[0])) bad_o++;
            if (!zone_n_i && seen_q && we0_n_i && (!oe_i || data_i !== cap_data_o))
                bad_o++;
        end
    end
endmodule : xbw_mem_model

// ### testbench/xbw_write_seq_tb.sv
// Testbench of the external write sequencer: APB stimulus, row table, odd cases.
// Assumes xbw_consts.svh on the include path and the partner model beside it.
`timescale 1ns/1ps
`include "xbw_consts.svh"
module xbw_write_seq_tb;
    typedef struct {
        logic [10:0] tim;
        logic [19:0] a;
        logic [31:0] d;
        logic [7:0] h;
        int slen;
        int zlen;
        logic str;
    } xbw_row_s;
    logic clk, srst, psel, pen, pwr, rdy, pready, pslverr, e;
    logic bclk, zone_n, dir, we0_n, we1_n, oe, bus32;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, ed, q, st, cap_d;
    logic [19:0] ea, cap_a;
    logic [7:0] hold;
    int slen, zlen, bad;
    int err_total = 0;
    int num_checks = 0;
    xbw_row_s rows [7];

    xbw_write_seq xbw_write_seq_inst (.clk_sys_i(clk), .srst_i(srst), .psel_i(psel),
        .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata),
        .external_wait_release_i(rdy), .pready_o(pready), .pslverr_o(pslverr),
        .prdata_o(prdata), .bus_clock_output_o(bclk), .zone_select_n_o(zone_n),
        .direction_line_o(dir), .write_strobe_low_lane_n_o(we0_n),
        .write_strobe_high_lane_n_o(we1_n), .ext_addr_o(ea), .ext_data_o(ed),
        .ext_data_oe_o(oe));

    xbw_mem_model xbw_mem_model_inst (.clk_sys_i(clk), .srst_i(srst), .bclk_i(bclk),
        .zone_n_i(zone_n), .dir_i(dir), .we0_n_i(we0_n), .we1_n_i(we1_n), .addr_i(ea),
        .data_i(ed), .oe_i(oe), .bus32_i(bus32), .hold_i(hold), .ready_o(rdy),
        .cap_addr_o(cap_a), .cap_data_o(cap_d), .strobe_len_o(slen),
        .zone_len_o(zlen), .bad_o(bad));

    task automatic summarize();
        if (err_total == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : summarize

    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        num_checks++;
        if (g !== x)
        begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, x, g);
        end
    endtask : chk

    task automatic rng(input string nm, input int lo, input int hi, input int g);
        num_checks++;
        if (g < lo || g > hi)
        begin
            err_total++;
            $display("Error %s expected %0d to %0d seen %0d", nm, lo, hi, g);
        end
    endtask : rng

    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        chk("apb_ready", 32'h0000_0001, {31'h0, pready});
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : apb

    // Program one access and start it; the far side gets its wait first
    task automatic go(input xbw_row_s r);
        @(posedge clk);
        hold <= r.h;
        bus32 <= r.tim[10];
        apb(1'b1, `XBW_OFF_TIMING, {21'h0, r.tim});
        apb(1'b1, `XBW_OFF_ADDR, {12'h0, r.a});
        apb(1'b1, `XBW_OFF_DATA, r.d);
        apb(1'b1, `XBW_OFF_CTRL, 32'h0000_0001);
    endtask : go

    // Poll status until done, keep it, then clear the sticky flag
    task automatic fin();
        int n;
        n = 0;
        do
        begin
            apb(1'b0, `XBW_OFF_STATUS, 32'h0000_0000);
            n++;
        end
        while (q[1] !== 1'b1 && n < 60);
        st = q;
        chk("done", 32'h0000_0001, {31'h0, st[1]});
        apb(1'b1, `XBW_OFF_STATUS, 32'h0000_0002);
    endtask : fin

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Watchdog well beyond the longest expected run
    initial
    begin
        repeat (40000) @(posedge clk);
        err_total++;
        summarize();
    end

    initial
    begin
        {psel, pen, pwr, bus32} = 4'h0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        hold = 8'h00;
        srst = 1'b1;
        rows = '{'{11'h4AD, 20'h0_1000, 32'hA5A5_0001, 8'h00, 6, 10, 1'b0},
            '{11'h07F, 20'h1_2345, 32'h0000_BEEF, 8'h28, 14, 26, 1'b0},
            '{11'h3CE, 20'hF_FFFE, 32'hFFFF_FFFF, 8'h00, 6, 14, 1'b0},
            '{11'h0AD, 20'h0_0003, 32'h1234_5678, 8'h1E, -1, -1, 1'b1},
            '{11'h5AD, 20'h8_0000, 32'h8765_4321, 8'h1E, -1, -1, 1'b1},
            '{11'h480, 20'h0_0010, 32'h0000_0000, 8'h00, 2, 6, 1'b0},
            '{11'h4AD, 20'h0_0021, 32'h5555_AAAA, 8'h02, 6, 10, 1'b0}};
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        // Table rows: sync, async, 16-bit, doubled clock, waits, minimum counts
        foreach (rows[i])
        begin
            go(rows[i]);
            fin();
            chk("data", rows[i].d, cap_d);
            chk("addr", {12'h0, rows[i].a}, {12'h0, cap_a});
            chk("stretched", {31'h0, rows[i].str}, {31'h0, st[2]});
            if (rows[i].slen < 0)
                rng("strobe_len", rows[i].h, rows[i].h + 12, slen);
            else
            begin
                chk("strobe_len", rows[i].slen, slen);
                chk("zone_len", rows[i].zlen, zlen);
            end
        end
        // Doubled clock again, started one timing cycle later; the start lands in the same phase and aligns again
        repeat (2) @(posedge clk);
        go(rows[2]);
        fin();
        chk("align_strobe_len", rows[2].slen, slen);
        chk("align_zone_len", rows[2].zlen, zlen);
        // Settings written while busy must not land
        go(rows[3]);
        apb(1'b1, `XBW_OFF_TIMING, 32'h0000_0000);
        fin();
        apb(1'b0, `XBW_OFF_TIMING, 32'h0000_0000);
        chk("timing_busy", 32'h0000_00AD, q);
        apb(1'b0, 12'h014, 32'h0000_0000);
        chk("unmapped_err", 32'h0000_0001, {31'h0, e});
        chk("unmapped_rd", 32'h0000_0000, q);
        // Reset in mid-access: pins idle, registers back to zero
        go(rows[4]);
        repeat (20) @(posedge clk);
        srst <= 1'b1;
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        chk("reset_pins", 32'h0000_0005, {29'h0, zone_n, oe, ea[0]});
        apb(1'b0, `XBW_OFF_TIMING, 32'h0000_0000);
        chk("timing_rst", 32'h0000_0000, q);
        apb(1'b0, `XBW_OFF_STATUS, 32'h0000_0000);
        chk("status_rst", 32'h0000_0000, q);
        apb(1'b0, `XBW_OFF_CTRL, 32'h0000_0000);
        chk("ctrl_rd", 32'h0000_0000, q);
        chk("bus_watch", 32'h0000_0000, bad);
        summarize();
    end
endmodule : xbw_write_seq_tb
